// ===== hdl/dn_hash_cfg.svh
// Constants of the domain name tag generator: sizes, limits and key values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DN_HASH_CFG_SVH
`define DN_HASH_CFG_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NAME_BYTES   32
`define NAME_BITS    256
`define TAG_BITS     16
`define CW_BITS      224
`define SYM_W        7
`define LEN_STEP     8'h07
`define LAST_BYTE    5'h1f
`define LAST_PICK    4'hf

// ----------------------------------------
// Byte filter and hash keys
// ----------------------------------------
`define MIN_BYTE     8'h20
`define KEY_MIN      4'h2
`define KEY_MAX      4'h9
`define KEY_DEFAULT  4'h4

`endif

// ===== hdl/dn_hash_pkg.sv
// Types shared by the domain name tag generator modules.
// Assumes dn_hash_cfg.svh is on the include path.
`include "dn_hash_cfg.svh"

package dn_hash_pkg;

	// ----------------------------------------
	// Data types
	// ----------------------------------------
	typedef logic [3:0]               key_t;
	typedef logic [`TAG_BITS-1:0]     tag_t;
	typedef logic [7:0]               cw_len_t;
	typedef logic [`CW_BITS-1:0]      codeword_t;
	typedef logic [`NAME_BITS-1:0]    name_t;

	// Controller states
	typedef enum logic [2:0] {
		S_IDLE,
		S_PACK_GO,
		S_PACK_WAIT,
		S_HASH_GO,
		S_HASH_WAIT,
		S_READY,
		S_NAME_ERR
	} ctrl_state_t;

	// Byte takes part in the codeword
	function automatic logic keep_byte(input logic [7:0] b);
		return (b >= `MIN_BYTE);
	endfunction

endpackage

// ===== hdl/hash_link_if.sv
// Internal link between the tag controller, the codeword packer and the hasher.
// Assumes all three parties run on the same clock.
interface hash_link_if;
	import dn_hash_pkg::*;

	name_t     name;
	logic      pack_start;
	codeword_t codeword;
	cw_len_t   cw_len;
	logic      pack_done;
	logic      pack_empty;
	logic      hash_start;
	key_t      hash_key;
	logic      hash_done;
	tag_t      tag;

	modport ctrl   (output name, pack_start, hash_start, hash_key,
	                input  pack_done, pack_empty, hash_done, tag);
	modport packer (input  name, pack_start,
	                output codeword, cw_len, pack_done, pack_empty);
	modport hasher (input  codeword, cw_len, hash_start, hash_key,
	                output hash_done, tag);
endinterface

// ===== hdl/codeword_packer.sv
// Filters the stored domain name one byte a cycle and packs 7-bit groups.
// Assumes pack_start is a one-cycle pulse and the name holds still meanwhile.
`include "dn_hash_cfg.svh"

module codeword_packer
	import dn_hash_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// Link to controller and hasher
	hash_link_if.packer link
);

	logic       running;
	logic [4:0] byte_idx;
	logic [7:0] cur_byte;

	// Current name byte, first byte in the low bits
	assign cur_byte = link.name[{byte_idx, 3'h0} +: 8];

	// ----------------------------------------
	// Byte scan
	// ----------------------------------------
	// Walk bytes from first to last
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			running  <= 1'b0;
			byte_idx <= 5'h00;
		end else if (link.pack_start) begin
			running  <= 1'b1;
			byte_idx <= 5'h00;
		end else if (running) begin
			byte_idx <= byte_idx + 5'h01;
			if (byte_idx == `LAST_BYTE) begin
				running <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Codeword build
	// ----------------------------------------
	// Append low seven bits of surviving bytes upward from bit 0
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link.codeword <= '0;
			link.cw_len   <= 8'h00;
		end else if (link.pack_start) begin
			link.codeword <= '0;
			link.cw_len   <= 8'h00;
		end else if (running && keep_byte(cur_byte)) begin
			link.codeword[link.cw_len +: `SYM_W] <= cur_byte[6:0];
			link.cw_len <= link.cw_len + `LEN_STEP;
		end
	end

	// Completion pulse and empty-name flag
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link.pack_done  <= 1'b0;
			link.pack_empty <= 1'b0;
		end else begin
			link.pack_done <= running && (byte_idx == `LAST_BYTE);
			if (link.pack_start) begin
				link.pack_empty <= 1'b0;
			end else if (running && (byte_idx == `LAST_BYTE)) begin
				link.pack_empty <= (link.cw_len == 8'h00) && !keep_byte(cur_byte);
			end
		end
	end

endmodule

// ===== hdl/stride_hasher.sv
// Picks every m-th codeword bit with wrap-around until 16 bits are held.
// Assumes a codeword of at least seven bits and a key from two to nine.
`include "dn_hash_cfg.svh"

module stride_hasher
	import dn_hash_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// Link to controller and packer
	hash_link_if.hasher link
);

	logic       running;
	logic [3:0] picks;
	cw_len_t    ptr;
	key_t       key_l;

	// Advance pointer by key, modulo codeword length; two folds cover len >= 7
	function automatic cw_len_t wrap_ptr(input cw_len_t p, input key_t k, input cw_len_t n);
		cw_len_t t;
		t = p + {4'h0, k};
		if (t >= n) t = t - n;
		if (t >= n) t = t - n;
		return t;
	endfunction

	// ----------------------------------------
	// Pick sequencing
	// ----------------------------------------
	// Start at bit 0 and stride through the codeword
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			running <= 1'b0;
			picks   <= 4'h0;
			ptr     <= 8'h00;
			key_l   <= `KEY_DEFAULT;
		end else if (link.hash_start) begin
			running <= 1'b1;
			picks   <= 4'h0;
			ptr     <= 8'h00;
			key_l   <= link.hash_key;
		end else if (running) begin
			picks <= picks + 4'h1;
			ptr   <= wrap_ptr(ptr, key_l, link.cw_len);
			if (picks == `LAST_PICK) begin
				running <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Tag fill
	// ----------------------------------------
	// First pick lands in tag bit 0, later picks fill upward
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link.tag       <= '0;
			link.hash_done <= 1'b0;
		end else begin
			link.hash_done <= running && (picks == `LAST_PICK);
			if (running) begin
				link.tag[picks] <= link.codeword[ptr];
			end
		end
	end

endmodule

// ===== hdl/domain_name_hash_ident.sv
// Domain master's domain name tag generator and collision re-keying control.
// Assumes all inputs come from logic on clk_in; pulses last one cycle.
// Collisions seen while a re-key runs are held and serviced right after it.
// A name with no byte of 20 hex or above yields no tag and raises the error flag.
`include "dn_hash_cfg.svh"

module domain_name_hash_ident
	import dn_hash_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	// Master role start and own name
	input  wire logic                  start_in,
	input  wire logic [`NAME_BITS-1:0] name_in,
	// Neighbour domain observation
	input  wire logic                  nbr_valid_in,
	input  wire logic [`TAG_BITS-1:0]  nbr_tag_in,
	input  wire logic [`NAME_BITS-1:0] nbr_name_in,
	// Collision reported by a node
	input  wire logic                  report_collision_in,
	// Tag and key for access plan frames
	output logic [`TAG_BITS-1:0]       domain_name_tag_out,
	output logic [3:0]                 hash_key_selector_out,
	output logic                       tag_valid_out,
	output logic                       tag_changed_out,
	// Status
	output logic                       busy_out,
	output logic                       name_error_out
);

	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	hash_link_if link ();

	ctrl_state_t state;
	ctrl_state_t next_state;
	key_t        key;
	tag_t        tag;
	logic        tag_valid;
	logic        tag_changed;
	logic        name_error;
	logic        rekey_run;
	logic        pending;
	logic        nbr_match;
	logic        collide_event;
	logic        start_ok;
	logic        rekey_go;
	logic        pack_finish;
	logic        hash_finish;

	// Next alternative key: step through two..nine, skipping the default
	function automatic key_t next_alt_key(input key_t k);
		key_t n;
		n = (k >= `KEY_MAX) ? `KEY_MIN : k + 4'h1;
		if (n == `KEY_DEFAULT) begin
			n = n + 4'h1;
		end
		return n;
	endfunction

	// Settled states: no pack or hash is running, so a start may be taken
	// and busy is low; the last tag or the error flag stands meanwhile
	// Shared by the start decode and the busy output so the two never disagree
	function automatic logic settled(input ctrl_state_t s);
		return (s == S_IDLE) || (s == S_READY) || (s == S_NAME_ERR);
	endfunction

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	// Byte filter and codeword packer
	codeword_packer i_codeword_packer (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.link     (link.packer)
	);

	// Stride hash over the codeword
	stride_hasher i_stride_hasher (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.link     (link.hasher)
	);

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	// Neighbour shows our tag while carrying a different name
	// Equal names are our own domain heard again, not a clash
	assign nbr_match = nbr_valid_in && tag_valid
	                   && (nbr_tag_in == tag)
	                   && (nbr_name_in != link.name);

	// Any collision that calls for a new key
	assign collide_event = nbr_match
	                       || (report_collision_in && tag_valid);

	// Start is taken when no computation runs
	assign start_ok = start_in && settled(state);

	// Re-key begins from the ready state
	// A start in the same cycle wins: a new role restarts from the default key
	assign rekey_go = !start_in
	                  && (state == S_READY)
	                  && (pending || collide_event);

	// ----------------------------------------
	// Completion decode
	// ----------------------------------------
	// Sub-block done pulses, qualified by the state that waits for them
	// One name for each, so every register below reacts to the same event
	assign pack_finish = (state == S_PACK_WAIT) && link.pack_done;
	assign hash_finish = (state == S_HASH_WAIT) && link.hash_done;

	// ----------------------------------------
	// Control state machine
	// ----------------------------------------
	// Next state selection
	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: begin
				if (start_ok) begin
					next_state = S_PACK_GO;
				end
			end
			S_PACK_GO: begin
				next_state = S_PACK_WAIT;
			end
			S_PACK_WAIT: begin
				if (link.pack_done) begin
					next_state = link.pack_empty ? S_NAME_ERR : S_HASH_GO;
				end
			end
			S_HASH_GO: begin
				next_state = S_HASH_WAIT;
			end
			S_HASH_WAIT: begin
				if (link.hash_done) begin
					next_state = S_READY;
				end
			end
			S_READY: begin
				if (start_ok) begin
					next_state = S_PACK_GO;
				end else if (rekey_go) begin
					next_state = S_HASH_GO;
				end
			end
			S_NAME_ERR: begin
				if (start_ok) begin
					next_state = S_PACK_GO;
				end
			end
			// Unused code of the state register: recover to idle
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Link drive
	// ----------------------------------------
	// Start strobes follow the launch states
	assign link.pack_start = (state == S_PACK_GO);
	assign link.hash_start = (state == S_HASH_GO);
	assign link.hash_key   = key;

	// Own name captured when the master role starts
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link.name <= '0;
		end else if (start_ok) begin
			link.name <= name_in;
		end
	end

	// ----------------------------------------
	// Hash key
	// ----------------------------------------
	// Default key for a new role, next alternative on collision
	// The default is never an alternative, so a clash cannot bring it back
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			key <= `KEY_DEFAULT;
		end else if (start_ok) begin
			key <= `KEY_DEFAULT;
		end else if (rekey_go) begin
			key <= next_alt_key(key);
		end
	end

	// Marks a run that replaces an advertised tag
	// Only such a run pulses tag_changed; a role's first tag is shown by tag_valid
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rekey_run <= 1'b0;
		end else if (start_ok) begin
			rekey_run <= 1'b0;
		end else if (rekey_go) begin
			rekey_run <= 1'b1;
		end
	end

	// ----------------------------------------
	// Collision memory
	// ----------------------------------------
	// Holds a collision seen while hashing; one seen in the ready state joins the re-key that clears it
	// Such an event may concern the old tag; a spare re-key beats a missed clash
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pending <= 1'b0;
		end else if (start_ok) begin
			pending <= 1'b0;
		end else if (collide_event && (state != S_READY)) begin
			pending <= 1'b1;
		end else if (rekey_go) begin
			pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// Tag and status outputs
	// ----------------------------------------
	// Tag taken when the hasher finishes
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tag <= '0;
		end else if (hash_finish) begin
			tag <= link.tag;
		end
	end

	// Tag valid once the default-key tag exists; old tag stays during re-key
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tag_valid <= 1'b0;
		end else if (start_ok) begin
			tag_valid <= 1'b0;
		end else if (hash_finish) begin
			tag_valid <= 1'b1;
		end
	end

	// One-cycle pulse when a re-keyed tag replaces the old one
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tag_changed <= 1'b0;
		end else begin
			tag_changed <= hash_finish && rekey_run;
		end
	end

	// Name without any usable byte
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			name_error <= 1'b0;
		end else if (start_ok) begin
			name_error <= 1'b0;
		end else if (pack_finish) begin
			name_error <= link.pack_empty;
		end
	end

	// Port drive
	assign domain_name_tag_out   = tag;
	assign hash_key_selector_out = key;
	assign tag_valid_out         = tag_valid;
	assign tag_changed_out       = tag_changed;
	assign name_error_out        = name_error;
	assign busy_out              = !settled(state);

endmodule

// ===== bench/dn_tag_assertions.sv
// Port-level assertions for the domain name tag generator.
// Assumes a bind to domain_name_hash_ident and one clock domain.
`include "dn_hash_cfg.svh"
module dn_tag_assertions (
	// Clock and reset
	input wire logic                  clk_in,
	input wire logic                  rst_b_in,
	// Stimulus side
	input wire logic                  start_in,
	input wire logic [`NAME_BITS-1:0] name_in,
	input wire logic                  nbr_valid_in,
	input wire logic [`TAG_BITS-1:0]  nbr_tag_in,
	input wire logic [`NAME_BITS-1:0] nbr_name_in,
	input wire logic                  report_collision_in,
	// Result side
	input wire logic [`TAG_BITS-1:0]  domain_name_tag_out,
	input wire logic [3:0]            hash_key_selector_out,
	input wire logic                  tag_valid_out,
	input wire logic                  tag_changed_out,
	input wire logic                  busy_out,
	input wire logic                  name_error_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	// Alternative key order, default skipped
	function automatic logic [3:0] next_key(input logic [3:0] k);
		return (k == 4'h9) ? 4'h2 : (k == 4'h3) ? 4'h5 : k + 4'h1;
	endfunction

	// ----------------------------------------
	// Accepted requests
	// ----------------------------------------
	sequence s_start;
		start_in && !busy_out;
	endsequence
	sequence s_ready;
		tag_valid_out && !busy_out && !start_in;
	endsequence
	sequence s_nbr_hit;
		nbr_valid_in && nbr_tag_in == domain_name_tag_out && nbr_name_in != name_in;
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_start;
		s_start |=> busy_out && !tag_valid_out && hash_key_selector_out == 4'h4;
	endproperty
	property p_finish;
		s_start |-> (##35 name_error_out) or (##53 tag_valid_out);
	endproperty
	property p_key_range;
		hash_key_selector_out >= 4'h2 && hash_key_selector_out <= 4'h9;
	endproperty
	property p_rekey_key;
		s_ready ##0 report_collision_in |=> busy_out && hash_key_selector_out == next_key($past(hash_key_selector_out));
	endproperty
	property p_rekey_done;
		s_ready ##0 report_collision_in |-> ##19 tag_changed_out;
	endproperty
	property p_nbr_rekey;
		s_ready ##0 s_nbr_hit |-> ##19 tag_changed_out;
	endproperty
	property p_pulse;
		tag_changed_out |=> !tag_changed_out;
	endproperty
	property p_hold;
		tag_valid_out && !tag_changed_out && !$rose(tag_valid_out) |-> $stable(domain_name_tag_out);
	endproperty
	property p_err;
		name_error_out |-> !tag_valid_out && !busy_out;
	endproperty

	a_start: assert property (p_start) else $error("start not taken");
	a_finish: assert property (p_finish) else $error("tag late");
	a_key_range: assert property (p_key_range) else $error("key out of range");
	a_rekey_key: assert property (p_rekey_key) else $error("bad next key");
	a_rekey_done: assert property (p_rekey_done) else $error("no new tag");
	a_nbr_rekey: assert property (p_nbr_rekey) else $error("no re-key on match");
	a_pulse: assert property (p_pulse) else $error("change pulse too long");
	a_hold: assert property (p_hold) else $error("tag moved");
	a_err: assert property (p_err) else $error("error with tag");
endmodule

// ===== bench/join_node_model.sv
// Joining node: recomputes the tag from a name and the advertised key.
// Assumes a key from two to nine; an empty codeword yields zero.
`include "dn_hash_cfg.svh"
module join_node_model (
	// Name and advertised key
	input  wire logic [`NAME_BITS-1:0] name_in,
	input  wire logic [3:0]            key_in,
	// Recomputed tag
	output logic      [`TAG_BITS-1:0]  tag_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Packs kept bytes, then picks every m-th bit with wrap
	function automatic logic [15:0] tag_of(input logic [255:0] nm, input logic [3:0] m);
		logic [223:0] cw;
		logic [15:0]  t;
		int           len;
		int           p;
		cw = '0;
		t = '0;
		len = 0;
		p = 0;
		for (int k = 0; k < 32; k++) begin
			if (nm[8*k +: 8] >= 8'h20) begin
				cw[len +: 7] = nm[8*k +: 7];
				len += 7;
			end
		end
		for (int i = 0; i < 16 && len > 0; i++) begin
			t[i] = cw[p];
			p = (p + m) % len;
		end
		return t;
	endfunction

	// Recheck with the key in the frame header
	always_comb begin
		tag_out = tag_of(name_in, key_in);
	end
endmodule

// ===== bench/domain_name_hash_ident_bench.sv
// Self-checking bench of the domain name tag generator.
// Assumes the checker and the joining node model are compiled first.
`include "dn_hash_cfg.svh"
`define CHECK(what, exp, got) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("Error %s expected %0h seen %0h", what, exp, got); \
	end \
end
module domain_name_hash_ident_bench;
	import dn_hash_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_in;
	logic        rst_b_in;
	logic        start_in;
	name_t       name_in;
	logic        nbr_valid_in;
	tag_t        nbr_tag_in;
	name_t       nbr_name_in;
	logic        report_collision_in;
	tag_t        domain_name_tag_out;
	key_t        hash_key_selector_out;
	logic        tag_valid_out;
	logic        tag_changed_out;
	logic        busy_out;
	logic        name_error_out;
	tag_t        ref_tag;
	key_t        exp_key;
	int          bad_count;
	int          tests_run;

	// ----------------------------------------
	// Design and far side
	// ----------------------------------------
	domain_name_hash_ident i_domain_name_hash_ident (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(start_in),
		.name_in(name_in), .nbr_valid_in(nbr_valid_in), .nbr_tag_in(nbr_tag_in), .nbr_name_in(nbr_name_in),
		.report_collision_in(report_collision_in), .domain_name_tag_out(domain_name_tag_out),
		.hash_key_selector_out(hash_key_selector_out), .tag_valid_out(tag_valid_out),
		.tag_changed_out(tag_changed_out), .busy_out(busy_out), .name_error_out(name_error_out));
	join_node_model i_join_node_model (.name_in(name_in), .key_in(hash_key_selector_out), .tag_out(ref_tag));

	// Clock of 50 ns
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic finish_test;
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy_out !== 1'b0 && n < 100) begin
			tick(1);
			n++;
		end
		if (busy_out !== 1'b0) begin
			bad_count++;
			finish_test();
		end
	endtask
	task automatic run_start(input name_t nm);
		name_in = nm;
		start_in = 1'b1;
		tick(1);
		start_in = 1'b0;
		wait_idle();
	endtask
	task automatic check_tag;
		`CHECK("tag_valid", 1'b1, tag_valid_out)
		`CHECK("tag", ref_tag, domain_name_tag_out)
	endtask
	function automatic key_t nk(input key_t k);
		return (k == 4'h9) ? 4'h2 : (k == 4'h3) ? 4'h5 : k + 4'h1;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_mixed;
		name_t nm;
		for (int k = 0; k < 32; k++)
			nm[8*k +: 8] = 8'(k * 8 + 3);
		run_start(nm);
		`CHECK("key", 4'h4, hash_key_selector_out)
		check_tag();
	endtask
	task automatic t_one_byte;
		run_start({8'ha5, {31{8'h1f}}});
		check_tag();
		`CHECK("name_error", 1'b0, name_error_out)
	endtask
	task automatic t_empty;
		run_start({32{8'h1f}});
		`CHECK("name_error", 1'b1, name_error_out)
		`CHECK("tag_valid", 1'b0, tag_valid_out)
	endtask
	task automatic t_rekey;
		name_t nm;
		for (int k = 0; k < 32; k++)
			nm[8*k +: 8] = 8'(8'h20 + k * 7);
		run_start(nm);
		check_tag();
		exp_key = 4'h4;
		for (int i = 0; i < 9; i++) begin
			exp_key = nk(exp_key);
			report_collision_in = 1'b1;
			tick(1);
			report_collision_in = 1'b0;
			wait_idle();
			`CHECK("tag_changed", 1'b1, tag_changed_out)
			`CHECK("key", exp_key, hash_key_selector_out)
			check_tag();
		end
	endtask
	task automatic t_neighbour;
		nbr_tag_in = domain_name_tag_out;
		nbr_name_in = name_in ^ 256'h1;
		nbr_valid_in = 1'b1;
		tick(1);
		nbr_valid_in = 1'b0;
		`CHECK("busy", 1'b1, busy_out)
		wait_idle();
		`CHECK("key", nk(exp_key), hash_key_selector_out)
		check_tag();
		exp_key = hash_key_selector_out;
		nbr_tag_in = domain_name_tag_out;
		nbr_name_in = name_in;
		nbr_valid_in = 1'b1;
		tick(1);
		nbr_valid_in = 1'b0;
		tick(2);
		`CHECK("busy", 1'b0, busy_out)
		`CHECK("key", exp_key, hash_key_selector_out)
	endtask
	task automatic t_pending;
		exp_key = hash_key_selector_out;
		report_collision_in = 1'b1;
		tick(1);
		report_collision_in = 1'b0;
		tick(1);
		report_collision_in = 1'b1;
		tick(1);
		report_collision_in = 1'b0;
		wait_idle();
		`CHECK("tag_changed", 1'b1, tag_changed_out)
		`CHECK("key", nk(exp_key), hash_key_selector_out)
		tick(1);
		`CHECK("busy", 1'b1, busy_out)
		wait_idle();
		`CHECK("tag_changed", 1'b1, tag_changed_out)
		`CHECK("key", nk(nk(exp_key)), hash_key_selector_out)
		check_tag();
	endtask

	// Main sequence
	initial begin
		bad_count = 0;
		tests_run = 0;
		rst_b_in = 1'b0;
		start_in = 1'b0;
		name_in = '0;
		nbr_valid_in = 1'b0;
		nbr_tag_in = '0;
		nbr_name_in = '0;
		report_collision_in = 1'b0;
		tick(16);
		rst_b_in = 1'b1;
		tick(1);
		`CHECK("key", 4'h4, hash_key_selector_out)
		`CHECK("tag", 16'h0000, domain_name_tag_out)
		t_mixed();
		t_one_byte();
		t_empty();
		t_rekey();
		t_neighbour();
		t_pending();
		finish_test();
	end
endmodule

bind domain_name_hash_ident dn_tag_assertions i_dn_tag_assertions (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.start_in(start_in), .name_in(name_in), .nbr_valid_in(nbr_valid_in), .nbr_tag_in(nbr_tag_in),
	.nbr_name_in(nbr_name_in), .report_collision_in(report_collision_in),
	.domain_name_tag_out(domain_name_tag_out), .hash_key_selector_out(hash_key_selector_out),
	.tag_valid_out(tag_valid_out), .tag_changed_out(tag_changed_out), .busy_out(busy_out),
	.name_error_out(name_error_out));
